// ### logic/radio_mode_register_page.sv
// Register page of the transceiver while the spread-spectrum modem is chosen:
// data FIFO port, operating mode, reserved words, carrier frequency word,
// the shared 0x0d..0x3f window and the banked 0x61..0x73 window.
// Assumes a classic Wishbone master on clk_i and a synchronous reset.
`default_nettype none

module radio_mode_register_page (
  // Clock and reset.
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  // Wishbone slave.
  input  wire radio_page_pkg::wb_req_t wb_i,
  output var  radio_page_pkg::wb_rsp_t wb_o,
  // Settings towards the modem and synthesizer.
  output var  radio_page_pkg::radio_ctl_t ctl_o,
  output logic [4:0]                   fifo_level_o
);

  // Returns true when an index lies inside an inclusive window.
  function automatic logic in_range(input logic [6:0] idx,
                                    input logic [6:0] lo,
                                    input logic [6:0] hi);
    in_range = (idx >= lo) && (idx <= hi);
  endfunction

  // Bus decode.
  logic [6:0] idx;        // Register index from the byte address.
  logic       aligned;    // Only whole-word addresses are mapped.
  logic       hit;        // Request taken at this edge.
  logic       wr;         // Write with the low byte lane enabled.
  logic       rd;         // Read taken at this edge.
  logic [7:0] wdat;       // Low byte of the write data.
  logic       ack_q;      // Registered acknowledge.
  logic [31:0] dat_q;     // Registered read data.
  logic [7:0] rd_d;       // Next read byte.

  // Operating mode fields.
  logic                       family_q;   // 1 selects spread spectrum.
  logic                       alt_q;      // Shared FSK window access.
  logic                       band_q;     // 1 selects the low band bank.
  radio_page_pkg::dev_state_t state_q;    // Device state.
  logic                       trig_q;     // One-cycle state change pulse.

  // Carrier frequency staging and committed word.
  logic [7:0]  frf_hi_q;
  logic [7:0]  frf_mid_q;
  logic [7:0]  frf_lo_q;
  logic [23:0] carrier_q;

  // FIFO storage and pointers.
  logic [7:0] fifo_mem [radio_page_pkg::FIFO_DEPTH];
  logic [3:0] wr_ptr_q;
  logic [3:0] rd_ptr_q;
  logic [4:0] fifo_cnt_q;
  logic       asleep;
  logic       fifo_push;
  logic       fifo_pop;

  // Windowed pages: FSK and spread-spectrum copies, and two band banks.
  logic [7:0] fsk_page [radio_page_pkg::PAGE_WORDS];
  logic [7:0] ss_page  [radio_page_pkg::PAGE_WORDS];
  logic [7:0] band_lo  [radio_page_pkg::BAND_WORDS];
  logic [7:0] band_hi  [radio_page_pkg::BAND_WORDS];
  logic [5:0] page_off;
  logic [4:0] band_off;
  logic       use_fsk;
  logic       in_page;
  logic       in_band;

  assign idx      = wb_i.adr[8:2];
  assign aligned  = (wb_i.adr[1:0] == 2'b00);
  assign hit      = wb_i.cyc && wb_i.stb && !ack_q;
  assign wr       = hit && wb_i.we && wb_i.sel[0] && aligned;
  assign rd       = hit && !wb_i.we && aligned;
  assign wdat     = wb_i.dat[7:0];
  assign asleep   = (state_q == radio_page_pkg::ST_SLEEP);
  assign in_page  = in_range(idx, radio_page_pkg::IDX_PAGE_LO,
                             radio_page_pkg::IDX_PAGE_HI);
  assign in_band  = in_range(idx, radio_page_pkg::IDX_BAND_LO,
                             radio_page_pkg::IDX_BAND_HI);
  assign page_off = 6'(idx - radio_page_pkg::IDX_PAGE_LO);
  assign band_off = 5'(idx - radio_page_pkg::IDX_BAND_LO);
  // The FSK page is reached in FSK mode, or through the shared bit.
  assign use_fsk  = !family_q || alt_q;

  // The port is dead while asleep, so a pop or push never moves pointers.
  assign fifo_push = wr && (idx == radio_page_pkg::IDX_FIFO) && !asleep &&
                     (fifo_cnt_q != 5'(radio_page_pkg::FIFO_DEPTH));
  assign fifo_pop  = rd && (idx == radio_page_pkg::IDX_FIFO) && !asleep &&
                     (fifo_cnt_q != 5'h00);

  // Read multiplexer; unmapped and reserved words answer with zero.
  always_comb begin
    rd_d = 8'h00;
    if (aligned) begin
      if (idx == radio_page_pkg::IDX_FIFO) begin
        // An empty or sleeping FIFO reads as zero.
        rd_d = fifo_pop ? fifo_mem[rd_ptr_q] : 8'h00;
      end else if (idx == radio_page_pkg::IDX_OPMODE) begin
        rd_d = {family_q, alt_q, 2'b00, band_q, state_q};
      end else if (idx == radio_page_pkg::IDX_FRF_HIGH) begin
        rd_d = frf_hi_q;
      end else if (idx == radio_page_pkg::IDX_FRF_MID) begin
        rd_d = frf_mid_q;
      end else if (idx == radio_page_pkg::IDX_FRF_LOW) begin
        rd_d = frf_lo_q;
      end else if (in_page) begin
        rd_d = use_fsk ? fsk_page[page_off] : ss_page[page_off];
      end else if (in_band) begin
        rd_d = band_q ? band_lo[band_off] : band_hi[band_off];
      end
    end
  end

  // Bus answer: one wait state, ack drops in the cycle after it was given.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= hit;
      if (hit) begin
        // Upper lanes always read zero; the registers are a byte wide.
        dat_q <= {24'h00_0000, rd_d};
      end
    end
  end

  // Operating mode register and the state change pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      family_q <= radio_page_pkg::FAMILY_RST;
      alt_q    <= radio_page_pkg::ALT_RST;
      band_q   <= radio_page_pkg::BAND_RST;
      state_q  <= radio_page_pkg::STATE_RST;
      trig_q   <= 1'b0;
    end else begin
      trig_q <= 1'b0;
      if (wr && (idx == radio_page_pkg::IDX_OPMODE)) begin
        // The family is checked against the state before this write, so a
        // write that both enters sleep and flips the family keeps the old family.
        if (asleep) begin
          family_q <= wdat[radio_page_pkg::OPM_FAMILY_BIT];
        end
        alt_q   <= wdat[radio_page_pkg::OPM_ALT_BIT];
        band_q  <= wdat[radio_page_pkg::OPM_BAND_BIT];
        state_q <= radio_page_pkg::dev_state_t'(wdat[2:0]);
        trig_q  <= 1'b1;
      end
    end
  end

  // Carrier frequency: upper bytes stage, the low byte commits the word.
  // Changing it outside sleep or idle is left to software discipline.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frf_hi_q  <= radio_page_pkg::FRF_HIGH_RST;
      frf_mid_q <= radio_page_pkg::FRF_MID_RST;
      frf_lo_q  <= radio_page_pkg::FRF_LOW_RST;
      carrier_q <= radio_page_pkg::FRF_WORD_RST;
    end else if (wr) begin
      if (idx == radio_page_pkg::IDX_FRF_HIGH) begin
        frf_hi_q <= wdat;
      end else if (idx == radio_page_pkg::IDX_FRF_MID) begin
        frf_mid_q <= wdat;
      end else if (idx == radio_page_pkg::IDX_FRF_LOW) begin
        frf_lo_q  <= wdat;
        // The synthesizer scales this word by the reference over 2**19.
        carrier_q <= {frf_hi_q, frf_mid_q, wdat};
      end
    end
  end

  // FIFO pointers; sleep empties the FIFO every cycle it lasts.
  always_ff @(posedge clk_i) begin
    if (rst_i || asleep) begin
      wr_ptr_q   <= 4'h0;
      rd_ptr_q   <= 4'h0;
      fifo_cnt_q <= 5'h00;
    end else begin
      if (fifo_push) begin
        wr_ptr_q <= wr_ptr_q + 4'h1;
      end
      if (fifo_pop) begin
        rd_ptr_q <= rd_ptr_q + 4'h1;
      end
      fifo_cnt_q <= fifo_cnt_q + 5'(fifo_push) - 5'(fifo_pop);
    end
  end

  // FIFO storage needs no reset; the count guards every read.
  always_ff @(posedge clk_i) begin
    if (fifo_push) begin
      fifo_mem[wr_ptr_q] <= wdat;
    end
  end

  // Shared window: a write lands only in the page that is routed now.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < radio_page_pkg::PAGE_WORDS; i++) begin
        fsk_page[i] <= 8'h00;
        ss_page[i]  <= 8'h00;
      end
    end else if (wr && in_page) begin
      if (use_fsk) begin
        fsk_page[page_off] <= wdat;
      end else begin
        ss_page[page_off] <= wdat;
      end
    end
  end

  // Band banks: the copy not selected keeps its value untouched.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < radio_page_pkg::BAND_WORDS; i++) begin
        band_lo[i] <= 8'h00;
        band_hi[i] <= 8'h00;
      end
    end else if (wr && in_band) begin
      if (band_q) begin
        band_lo[band_off] <= wdat;
      end else begin
        band_hi[band_off] <= wdat;
      end
    end
  end

  // Outputs come straight from flip-flops. Each carrier is driven whole by
  // one assignment, so no tool sees several drivers on one packed variable.
  assign wb_o         = '{ack: ack_q, dat: dat_q};
  assign ctl_o        = '{modem_family_select:  family_q,
                          alt_page_access:      alt_q,
                          low_band_bank_select: band_q,
                          state:                state_q,
                          state_trigger:        trig_q,
                          carrier_word:         carrier_q};
  assign fifo_level_o = fifo_cnt_q;

  // Checks on the logic above.
  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_q |=> !ack_q)
    else $error("ack held longer than one cycle");

  a_ack_follows_req: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_i.cyc && wb_i.stb && !ack_q) |=> ack_q)
    else $error("request not acknowledged after one cycle");

  a_family_locked: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !asleep |=> $stable(family_q))
    else $error("modem family changed outside sleep");

  a_fifo_sleep_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    asleep |=> (fifo_cnt_q == 5'h00))
    else $error("fifo not emptied in sleep");

  a_fifo_sleep_read: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd && asleep && idx == radio_page_pkg::IDX_FIFO) |=> (dat_q == 32'h0))
    else $error("fifo read returned data in sleep");

  a_carrier_commit: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == radio_page_pkg::IDX_FRF_LOW) |=>
      (carrier_q == {$past(frf_hi_q), $past(frf_mid_q), $past(wdat)}))
    else $error("carrier word not committed by low byte");

  a_carrier_staged: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(wr && idx == radio_page_pkg::IDX_FRF_LOW) |=> $stable(carrier_q))
    else $error("carrier word changed without low byte write");

  a_reserved_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd && in_range(idx, radio_page_pkg::IDX_RSVD_LO,
                    radio_page_pkg::IDX_RSVD_HI)) ##1 ack_q
      |-> (dat_q == 32'h0))
    else $error("reserved word read nonzero");

  a_opmode_rsvd_bits: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (rd && idx == radio_page_pkg::IDX_OPMODE) |=>
      (dat_q[5:4] == 2'b00 && dat_q[2:0] == $past(state_q)))
    else $error("operating mode read back wrong");

  a_state_trigger: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr && idx == radio_page_pkg::IDX_OPMODE) |=>
      (trig_q && state_q == $past(wdat[2:0])) ##1 !trig_q)
    else $error("state write did not trigger once");

  c_fifo_round_trip: cover property (@(posedge clk_i) disable iff (rst_i)
    fifo_push ##[1:20] fifo_pop);

  c_family_switch: cover property (@(posedge clk_i) disable iff (rst_i)
    $rose(family_q));

  c_shared_window: cover property (@(posedge clk_i) disable iff (rst_i)
    wr && in_page && family_q && alt_q);

  c_carrier_commit: cover property (@(posedge clk_i) disable iff (rst_i)
    wr && idx == radio_page_pkg::IDX_FRF_LOW);

endmodule

`default_nettype wire

// ### logic/radio_page_pkg.sv
// Package for the radio mode register page: offsets, reset values, field
// positions, device states and the bus and control carriers.
// Assumes a 32-bit classic Wishbone bus with byte addresses, one register
// per aligned word, register index equal to byte address divided by four.
`default_nettype none

package radio_page_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [6:0] IDX_FIFO     = 7'h00;
  localparam logic [6:0] IDX_OPMODE   = 7'h01;
  localparam logic [6:0] IDX_RSVD_LO  = 7'h02;
  localparam logic [6:0] IDX_RSVD_HI  = 7'h05;
  localparam logic [6:0] IDX_FRF_HIGH = 7'h06;
  localparam logic [6:0] IDX_FRF_MID  = 7'h07;
  localparam logic [6:0] IDX_FRF_LOW  = 7'h08;
  localparam logic [6:0] IDX_PAGE_LO  = 7'h0d;
  localparam logic [6:0] IDX_PAGE_HI  = 7'h3f;
  localparam logic [6:0] IDX_BAND_LO  = 7'h61;
  localparam logic [6:0] IDX_BAND_HI  = 7'h73;

  // Sizes of the windowed pages and of the data FIFO.
  localparam int PAGE_WORDS = 51;
  localparam int BAND_WORDS = 19;
  localparam int FIFO_DEPTH = 16;

  // Operating-mode field positions.
  localparam int OPM_FAMILY_BIT = 7;
  localparam int OPM_ALT_BIT    = 6;
  localparam int OPM_BAND_BIT   = 3;

  // Reset values.
  localparam logic        FAMILY_RST   = 1'b0;
  localparam logic        ALT_RST      = 1'b0;
  localparam logic        BAND_RST     = 1'b1;
  localparam logic [7:0]  FRF_HIGH_RST = 8'h6c;
  localparam logic [7:0]  FRF_MID_RST  = 8'h80;
  localparam logic [7:0]  FRF_LOW_RST  = 8'h00;
  localparam logic [23:0] FRF_WORD_RST = 24'h6c8000;

  // Synthesizer scaling: carrier = ref * word / 2**FRF_SHIFT.
  localparam int FRF_SHIFT  = 19;
  localparam int REF_OSC_HZ = 32000000;

  // Device states held in the low three bits of the operating mode.
  typedef enum logic [2:0] {
    ST_SLEEP        = 3'b000,
    ST_IDLE_READY   = 3'b001,
    ST_TX_SYNTH     = 3'b010,
    ST_TRANSMIT     = 3'b011,
    ST_RX_SYNTH     = 3'b100,
    ST_RX_UNENDING  = 3'b101,
    ST_RX_ONE_SHOT  = 3'b110,
    ST_CHAN_PROBE   = 3'b111
  } dev_state_t;

  localparam dev_state_t STATE_RST = ST_IDLE_READY;

  // Wishbone request from the master.
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [8:0]  adr;
    logic [31:0] dat;
  } wb_req_t;

  // Wishbone answer to the master.
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Settings handed to the modem and synthesizer.
  typedef struct packed {
    logic        modem_family_select;
    logic        alt_page_access;
    logic        low_band_bank_select;
    dev_state_t  state;
    logic        state_trigger;
    logic [23:0] carrier_word;
  } radio_ctl_t;

endpackage

`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the radio mode register page.
// Assumes the page answers classic Wishbone with a one-cycle registered ack.
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  // Clock, reset and the bus carriers.
  logic                       clk_i;
  logic                       rst_i;
  radio_page_pkg::wb_req_t    wb_i;
  radio_page_pkg::wb_rsp_t    wb_o;
  radio_page_pkg::radio_ctl_t ctl_o;
  logic [4:0]                 fifo_level_o;
  // Counters for the closing report.
  int                         n_errors;
  int                         num_checks;
  int                         cycles;

  radio_mode_register_page u_dut (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .wb_i         (wb_i),
    .wb_o         (wb_o),
    .ctl_o        (ctl_o),
    .fifo_level_o (fifo_level_o)
  );

  // A 25 ns period gives the 40 MHz system clock.
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic stop_test();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One classic cycle; the request is held until ack is seen at an edge.
  task automatic bus(input logic we, input logic [8:0] a,
                     input logic [7:0] d, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_i <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a,
              dat: {24'h000000, d}};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_o.ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    end
    r = wb_o.dat[7:0];
    wb_i <= '0;
  endtask

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, a, d, r);
  endtask

  // Reads a byte register and compares it with the expected byte.
  task automatic rdc(input logic [8:0] a, input logic [7:0] e);
    logic [7:0] r;
    bus(1'b0, a, 8'h00, r);
    chk({24'h0, r}, {24'h0, e});
  endtask

  task automatic t_reset();
    rdc(9'h004, 8'h09);
    rdc(9'h018, 8'h6c);
    rdc(9'h01c, 8'h80);
    rdc(9'h020, 8'h00);
    chk({8'h0, ctl_o.carrier_word}, 32'h006c8000);
    chk({31'h0, ctl_o.low_band_bank_select}, 32'h1);
  endtask

  // Reserved words and bits must ignore writes and read zero.
  task automatic t_reserved();
    for (int i = 2; i <= 5; i++) begin
      wr(9'(i * 4), 8'hff);
      rdc(9'(i * 4), 8'h00);
    end
    wr(9'h004, 8'h39);
    rdc(9'h004, 8'h09);
  endtask

  // The family bit only moves when the state before the write is sleep.
  task automatic t_family();
    wr(9'h004, 8'h89);
    chk({31'h0, ctl_o.modem_family_select}, 32'h0);
    wr(9'h004, 8'h08);
    wr(9'h004, 8'h88);
    chk({31'h0, ctl_o.modem_family_select}, 32'h1);
    rdc(9'h004, 8'h88);
  endtask

  // Every state code is written in turn and seen at the outputs.
  task automatic t_states();
    for (int s = 0; s < 8; s++) begin
      wr(9'h004, {5'h11, 3'(s)});
      chk({31'h0, ctl_o.state_trigger}, 32'h1);
      chk({29'h0, ctl_o.state}, 32'(s));
      rdc(9'h004, {5'h11, 3'(s)});
    end
    wr(9'h004, 8'h89);
  endtask

  // Sleep empties the FIFO and shuts its port.
  task automatic t_fifo();
    wr(9'h000, 8'ha5);
    wr(9'h000, 8'h5a);
    chk({27'h0, fifo_level_o}, 32'h2);
    rdc(9'h000, 8'ha5);
    wr(9'h004, 8'h88);
    // Sleep empties the FIFO one edge after the state has changed.
    @(posedge clk_i);
    chk({27'h0, fifo_level_o}, 32'h0);
    wr(9'h000, 8'h77);
    chk({27'h0, fifo_level_o}, 32'h0);
    rdc(9'h000, 8'h00);
    wr(9'h004, 8'h89);
  endtask

  // The shared window reaches one copy or the other by bit 6 and family.
  task automatic t_window();
    wr(9'h034, 8'h55);
    wr(9'h004, 8'hc9);
    chk({31'h0, ctl_o.alt_page_access}, 32'h1);
    rdc(9'h034, 8'h00);
    wr(9'h034, 8'haa);
    wr(9'h004, 8'h89);
    rdc(9'h034, 8'h55);
    wr(9'h004, 8'h88);
    wr(9'h004, 8'h08);
    rdc(9'h034, 8'haa);
  endtask

  // Both band copies keep their contents across bank switches.
  task automatic t_band();
    wr(9'h004, 8'h09);
    wr(9'h184, 8'h11);
    wr(9'h004, 8'h01);
    chk({31'h0, ctl_o.low_band_bank_select}, 32'h0);
    rdc(9'h184, 8'h00);
    wr(9'h184, 8'h22);
    wr(9'h004, 8'h09);
    rdc(9'h184, 8'h11);
    wr(9'h004, 8'h01);
    rdc(9'h184, 8'h22);
  endtask

  // Upper bytes only stage; the low byte commits the whole word.
  task automatic t_carrier();
    wr(9'h018, 8'h12);
    wr(9'h01c, 8'h34);
    chk({8'h0, ctl_o.carrier_word}, 32'h006c8000);
    rdc(9'h018, 8'h12);
    wr(9'h020, 8'h56);
    @(posedge clk_i);
    chk({8'h0, ctl_o.carrier_word}, 32'h00123456);
    rdc(9'h01c, 8'h34);
    rdc(9'h020, 8'h56);
    rdc(9'h1fc, 8'h00);
  endtask

  // Hang guard; the whole sequence needs well under a thousand cycles.
  always @(posedge clk_i) begin
    cycles++;
    if (cycles >= 5000) begin
      n_errors++;
      stop_test();
    end
  end

  // Main sequence: reset for five cycles, then each scenario in turn.
  initial begin
    n_errors = 0;
    num_checks = 0;
    cycles = 0;
    rst_i = 1'b1;
    wb_i = '0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_reserved();
    t_family();
    t_states();
    t_fifo();
    t_window();
    t_band();
    t_carrier();
    stop_test();
  end
endmodule

`default_nettype wire
